// file: verilog/gitg_timing_gen.sv
// gated intensifier timing generator with axi4-lite register access
`timescale 1ns/100ps
`default_nettype none
module gitg_timing_gen (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // trigger pin
  input  wire logic        trig_in,
  // pulse set and sensor control
  output logic             plate_gain_gate,
  output logic             gate_open_edge,
  output logic             gate_close_edge,
  output logic             spare_pulse_one,
  output logic             master_sync_out_a,
  output logic             master_sync_out_b,
  output logic             exposure_active,
  output logic             cathode_bias_on,
  output logic             idle_flush
);
  localparam int unsigned TW = gitg_pkg::TW;
  localparam int unsigned NW = gitg_pkg::NW;

  // merge a write into an old value under the byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge_strb

  // address decode shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] a, input logic for_write);
    logic ok;
    ok = (a[1:0] == 2'b00) && (a <= gitg_pkg::OFS_CURD);
    if (for_write && a >= gitg_pkg::OFS_STATUS) ok = 1'b0;
    return ok;
  endfunction : addr_mapped

  // configuration registers
  logic [gitg_pkg::CTRL_W-1:0] ctrl_ff;
  logic [19:0]   freq_ff;
  logic [TW-1:0] wstart_ff, wend_ff, dstart_ff, dend_ff;
  logic [NW-1:0] frames_ff, gates_ff, syncb_us_ff;
  logic [TW-1:0] auxw_ff, auxd_ff, syncw_ff;

  // bus state
  logic [7:0]  awaddr_ff;
  logic        aw_have_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        w_have_ff;
  logic        do_write;
  logic [31:0] wmerged;
  logic [31:0] rd_word;

  // sequencer state
  gitg_pkg::gitg_state_e state_ff;
  logic [31:0]   t_ff;
  logic [NW-1:0] gate_cnt_ff, frame_ff;
  logic [1:0]    tail_ff;
  logic          calc_go_ff;
  logic          wdone_ff, ddone_ff;
  logic [TW-1:0] curw_ff, curd_ff;
  logic [TW:0]   set_end, gate_end, aux_end;

  // trigger sources
  logic [2:0]  trig_sync_ff;
  logic        trig_lvl_ff;
  logic        ext_edge;
  logic [31:0] phase_ff;
  logic [19:0] freq_eff;
  logic        int_tick_ff;
  logic        trig_evt;

  // delayed sync copy
  logic [31:0]   b_t_ff;
  logic          b_run_ff;
  logic [TW-1:0] b_dly;
  logic [TW:0]   b_end;

  // sweep arithmetic
  logic          w_neg, d_neg;
  logic [TW-1:0] w_mag, d_mag;
  logic          sweep_on;
  gitg_div_if    wdiv ();
  gitg_div_if    ddiv ();

  // ---------------- axi4-lite slave ----------------
  assign s_axi_awready = !aw_have_ff;
  assign s_axi_wready  = !w_have_ff;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_have_ff && w_have_ff && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awaddr_ff    <= 8'h00;
      aw_have_ff   <= 1'b0;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      w_have_ff    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gitg_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_ff) begin
        awaddr_ff  <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
      end
      if (s_axi_wvalid && !w_have_ff) begin
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        w_have_ff <= 1'b1;
      end
      if (do_write) begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(awaddr_ff, 1'b1) ? gitg_pkg::RESP_OKAY : gitg_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_ff)
      gitg_pkg::OFS_CTRL:     rd_word = 32'(ctrl_ff);
      gitg_pkg::OFS_FREQ:     rd_word = 32'(freq_ff);
      gitg_pkg::OFS_WSTART:   rd_word = 32'(wstart_ff);
      gitg_pkg::OFS_WEND:     rd_word = 32'(wend_ff);
      gitg_pkg::OFS_DSTART:   rd_word = 32'(dstart_ff);
      gitg_pkg::OFS_DEND:     rd_word = 32'(dend_ff);
      gitg_pkg::OFS_FRAMES:   rd_word = 32'(frames_ff);
      gitg_pkg::OFS_GATES:    rd_word = 32'(gates_ff);
      gitg_pkg::OFS_SYNCB_US: rd_word = 32'(syncb_us_ff);
      gitg_pkg::OFS_AUXW:     rd_word = 32'(auxw_ff);
      gitg_pkg::OFS_AUXD:     rd_word = 32'(auxd_ff);
      gitg_pkg::OFS_SYNCW:    rd_word = 32'(syncw_ff);
      default:                rd_word = 32'h0000_0000;
    endcase
  end
  assign wmerged = merge_strb(rd_word, wdata_ff, wstrb_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff     <= gitg_pkg::CTRL_RST;
      freq_ff     <= gitg_pkg::FREQ_RST;
      wstart_ff   <= gitg_pkg::TIME_RST;
      wend_ff     <= gitg_pkg::TIME_RST;
      dstart_ff   <= gitg_pkg::TIME_RST;
      dend_ff     <= gitg_pkg::TIME_RST;
      frames_ff   <= gitg_pkg::CNT_RST;
      gates_ff    <= gitg_pkg::CNT_RST;
      syncb_us_ff <= '0;
      auxw_ff     <= gitg_pkg::TIME_RST;
      auxd_ff     <= gitg_pkg::TIME_RST;
      syncw_ff    <= gitg_pkg::SYNCW_RST;
    end else if (do_write) begin
      case (awaddr_ff)
        gitg_pkg::OFS_CTRL:     ctrl_ff     <= wmerged[gitg_pkg::CTRL_W-1:0];
        gitg_pkg::OFS_FREQ:     freq_ff     <= wmerged[19:0];
        gitg_pkg::OFS_WSTART:   wstart_ff   <= wmerged[TW-1:0];
        gitg_pkg::OFS_WEND:     wend_ff     <= wmerged[TW-1:0];
        gitg_pkg::OFS_DSTART:   dstart_ff   <= wmerged[TW-1:0];
        gitg_pkg::OFS_DEND:     dend_ff     <= wmerged[TW-1:0];
        gitg_pkg::OFS_FRAMES:   frames_ff   <= wmerged[NW-1:0];
        gitg_pkg::OFS_GATES:    gates_ff    <= wmerged[NW-1:0];
        gitg_pkg::OFS_SYNCB_US: syncb_us_ff <= wmerged[NW-1:0];
        gitg_pkg::OFS_AUXW:     auxw_ff     <= wmerged[TW-1:0];
        gitg_pkg::OFS_AUXD:     auxd_ff     <= wmerged[TW-1:0];
        gitg_pkg::OFS_SYNCW:    syncw_ff    <= wmerged[TW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gitg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_mapped(s_axi_araddr, 1'b0) ? gitg_pkg::RESP_OKAY : gitg_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        gitg_pkg::OFS_CTRL:     s_axi_rdata <= 32'(ctrl_ff);
        gitg_pkg::OFS_FREQ:     s_axi_rdata <= 32'(freq_ff);
        gitg_pkg::OFS_WSTART:   s_axi_rdata <= 32'(wstart_ff);
        gitg_pkg::OFS_WEND:     s_axi_rdata <= 32'(wend_ff);
        gitg_pkg::OFS_DSTART:   s_axi_rdata <= 32'(dstart_ff);
        gitg_pkg::OFS_DEND:     s_axi_rdata <= 32'(dend_ff);
        gitg_pkg::OFS_FRAMES:   s_axi_rdata <= 32'(frames_ff);
        gitg_pkg::OFS_GATES:    s_axi_rdata <= 32'(gates_ff);
        gitg_pkg::OFS_SYNCB_US: s_axi_rdata <= 32'(syncb_us_ff);
        gitg_pkg::OFS_AUXW:     s_axi_rdata <= 32'(auxw_ff);
        gitg_pkg::OFS_AUXD:     s_axi_rdata <= 32'(auxd_ff);
        gitg_pkg::OFS_SYNCW:    s_axi_rdata <= 32'(syncw_ff);
        gitg_pkg::OFS_STATUS:   s_axi_rdata <= {frame_ff, 10'h000, wstart_ff != wend_ff,
                                                dstart_ff != dend_ff, state_ff, exposure_active,
                                                state_ff != gitg_pkg::ST_WAIT};
        gitg_pkg::OFS_CURW:     s_axi_rdata <= 32'(curw_ff);
        gitg_pkg::OFS_CURD:     s_axi_rdata <= 32'(curd_ff);
        default:                s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- trigger sources ----------------
  // external pin: three stages, change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_ff <= 3'h0;
      trig_lvl_ff  <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[1:0], trig_in};
      if (trig_sync_ff[1] == trig_sync_ff[2]) trig_lvl_ff <= trig_sync_ff[2];
    end
  end
  assign ext_edge = (trig_sync_ff[1] == trig_sync_ff[2]) && trig_sync_ff[2] && !trig_lvl_ff;

  // phase accumulator gives exact 1 Hz steps of the clock rate
  assign freq_eff = (freq_ff < gitg_pkg::FREQ_MIN_HZ) ? gitg_pkg::FREQ_MIN_HZ :
                    (freq_ff > gitg_pkg::FREQ_MAX_HZ) ? gitg_pkg::FREQ_MAX_HZ : freq_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff    <= 32'h0000_0000;
      int_tick_ff <= 1'b0;
    end else if (!ctrl_ff[gitg_pkg::CB_EN] || ctrl_ff[gitg_pkg::CB_EXT]) begin
      phase_ff    <= 32'h0000_0000;
      int_tick_ff <= 1'b0;
    end else if (phase_ff + 32'(freq_eff) >= gitg_pkg::CLK_HZ) begin
      phase_ff    <= phase_ff + 32'(freq_eff) - gitg_pkg::CLK_HZ;
      int_tick_ff <= 1'b1;
    end else begin
      phase_ff    <= phase_ff + 32'(freq_eff);
      int_tick_ff <= 1'b0;
    end
  end

  // one source only, every set started by its own event
  assign trig_evt = ctrl_ff[gitg_pkg::CB_EXT] ? ext_edge : int_tick_ff;

  // ---------------- sweep arithmetic ----------------
  assign sweep_on = ctrl_ff[gitg_pkg::CB_SEQ] && (frames_ff > 16'h0001);
  assign w_neg    = wend_ff < wstart_ff;
  assign d_neg    = dend_ff < dstart_ff;
  assign w_mag    = w_neg ? wstart_ff - wend_ff : wend_ff - wstart_ff;
  assign d_mag    = d_neg ? dstart_ff - dend_ff : dend_ff - dstart_ff;

  // value for frame i = start + (end - start) * i / (frames - 1)
  assign wdiv.go       = calc_go_ff;
  assign wdiv.dividend = w_mag * frame_ff;
  assign wdiv.divisor  = frames_ff - 16'h0001;
  assign ddiv.go       = calc_go_ff;
  assign ddiv.dividend = d_mag * frame_ff;
  assign ddiv.divisor  = frames_ff - 16'h0001;

  gitg_divider u_wdiv (
    .clk   (clk),
    .rst_n (rst_n),
    .dv    (wdiv)
  );
  gitg_divider u_ddiv (
    .clk   (clk),
    .rst_n (rst_n),
    .dv    (ddiv)
  );

  // ---------------- pulse set sequencer ----------------
  assign gate_end = {1'b0, curd_ff} + {1'b0, curw_ff};
  assign aux_end  = {1'b0, auxd_ff} + {1'b0, auxw_ff};
  always_comb begin
    set_end = {1'b0, syncw_ff};
    // one cycle past the gate so the close edge falls inside the set
    if (gate_end + 1'b1 > set_end) set_end = gate_end + 1'b1;
    if (aux_end > set_end) set_end = aux_end;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= gitg_pkg::ST_CALC;
      t_ff        <= 32'h0000_0000;
      gate_cnt_ff <= '0;
      frame_ff    <= '0;
      tail_ff     <= 2'h0;
      calc_go_ff  <= 1'b0;
      wdone_ff    <= 1'b0;
      ddone_ff    <= 1'b0;
      curw_ff     <= gitg_pkg::TIME_RST;
      curd_ff     <= gitg_pkg::TIME_RST;
    end else if (!ctrl_ff[gitg_pkg::CB_EN]) begin
      state_ff    <= gitg_pkg::ST_CALC;
      t_ff        <= 32'h0000_0000;
      tail_ff     <= 2'h0;
      gate_cnt_ff <= '0;
      frame_ff    <= '0;
      calc_go_ff  <= 1'b0;
      wdone_ff    <= 1'b0;
      ddone_ff    <= 1'b0;
    end else begin
      calc_go_ff <= 1'b0;
      case (state_ff)
        gitg_pkg::ST_CALC: begin
          if (!sweep_on) begin
            curw_ff  <= wstart_ff;
            curd_ff  <= dstart_ff;
            state_ff <= gitg_pkg::ST_WAIT;
          end else if (!calc_go_ff && !wdone_ff && !ddone_ff && t_ff == 32'h0000_0000) begin
            calc_go_ff <= 1'b1;
            t_ff       <= 32'h0000_0001;
          end else begin
            if (wdiv.done) begin
              wdone_ff <= 1'b1;
              curw_ff  <= w_neg ? wstart_ff - wdiv.quotient[TW-1:0] : wstart_ff + wdiv.quotient[TW-1:0];
            end
            if (ddiv.done) begin
              ddone_ff <= 1'b1;
              curd_ff  <= d_neg ? dstart_ff - ddiv.quotient[TW-1:0] : dstart_ff + ddiv.quotient[TW-1:0];
            end
            if ((wdone_ff || wdiv.done) && (ddone_ff || ddiv.done)) begin
              wdone_ff <= 1'b0;
              ddone_ff <= 1'b0;
              t_ff     <= 32'h0000_0000;
              state_ff <= gitg_pkg::ST_WAIT;
            end
          end
        end
        gitg_pkg::ST_WAIT: begin
          if (trig_evt) begin
            t_ff     <= 32'h0000_0000;
            state_ff <= gitg_pkg::ST_SET;
          end
        end
        gitg_pkg::ST_SET: begin
          // triggers are not looked at here
          t_ff <= t_ff + 32'h0000_0001;
          if (t_ff + 32'h0000_0001 >= 32'(set_end)) begin
            if (gate_cnt_ff + 16'h0001 >= gates_ff) begin
              gate_cnt_ff <= '0;
              tail_ff     <= 2'(gitg_pkg::EXPO_TAIL_CYC);
              state_ff    <= gitg_pkg::ST_TAIL;
            end else begin
              gate_cnt_ff <= gate_cnt_ff + 16'h0001;
              state_ff    <= gitg_pkg::ST_WAIT;
            end
          end
        end
        gitg_pkg::ST_TAIL: begin
          tail_ff <= tail_ff - 2'h1;
          if (tail_ff <= 2'h1) begin
            t_ff     <= 32'h0000_0000;
            frame_ff <= (frame_ff + 16'h0001 >= frames_ff) ? '0 : frame_ff + 16'h0001;
            state_ff <= gitg_pkg::ST_CALC;
          end
        end
        default: state_ff <= gitg_pkg::ST_CALC;
      endcase
    end
  end

  // ---------------- delayed copy of sync A ----------------
  assign b_dly = TW'(syncb_us_ff) * TW'(gitg_pkg::CYC_PER_US);
  assign b_end = {1'b0, b_dly} + {1'b0, syncw_ff};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_t_ff   <= 32'h0000_0000;
      b_run_ff <= 1'b0;
    end else if (state_ff == gitg_pkg::ST_WAIT && trig_evt && ctrl_ff[gitg_pkg::CB_SYNC]) begin
      b_t_ff   <= 32'h0000_0000;
      b_run_ff <= 1'b1;
    end else if (b_run_ff) begin
      b_t_ff <= b_t_ff + 32'h0000_0001;
      if (b_t_ff + 32'h0000_0001 >= 32'(b_end)) b_run_ff <= 1'b0;
    end
  end

  // ---------------- registered outputs ----------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      plate_gain_gate   <= 1'b0;
      gate_open_edge    <= 1'b0;
      gate_close_edge   <= 1'b0;
      spare_pulse_one   <= 1'b0;
      master_sync_out_a <= 1'b0;
      master_sync_out_b <= 1'b0;
      exposure_active   <= 1'b0;
      cathode_bias_on   <= 1'b0;
      idle_flush        <= 1'b0;
    end else begin
      plate_gain_gate   <= state_ff == gitg_pkg::ST_SET && t_ff >= 32'(curd_ff) && t_ff < 32'(gate_end);
      gate_open_edge    <= state_ff == gitg_pkg::ST_SET && t_ff == 32'(curd_ff);
      gate_close_edge   <= state_ff == gitg_pkg::ST_SET && t_ff == 32'(gate_end);
      spare_pulse_one   <= state_ff == gitg_pkg::ST_SET && t_ff >= 32'(auxd_ff) && t_ff < 32'(aux_end);
      master_sync_out_a <= ctrl_ff[gitg_pkg::CB_SYNC] && state_ff == gitg_pkg::ST_SET &&
                           t_ff < 32'(syncw_ff);
      master_sync_out_b <= b_run_ff && b_t_ff >= 32'(b_dly) && b_t_ff < 32'(b_end);
      exposure_active   <= state_ff == gitg_pkg::ST_SET ||
                           state_ff == gitg_pkg::ST_TAIL ||
                           (state_ff == gitg_pkg::ST_WAIT && gate_cnt_ff != '0);
      cathode_bias_on   <= ctrl_ff[gitg_pkg::CB_GBIAS] ?
                           (state_ff == gitg_pkg::ST_SET && t_ff >= 32'(curd_ff) && t_ff < 32'(gate_end)) :
                           ctrl_ff[gitg_pkg::CB_EN];
      idle_flush        <= ctrl_ff[gitg_pkg::CB_EN] && state_ff == gitg_pkg::ST_WAIT &&
                           gate_cnt_ff == '0;
    end
  end
endmodule : gitg_timing_gen
`default_nettype wire

// file: verilog/gitg_pkg.sv
// constants for the gated intensifier timing generator
package gitg_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int unsigned EXPO_TAIL_NS = 15;
  localparam int unsigned EXPO_TAIL_CYC = (EXPO_TAIL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [19:0] FREQ_MIN_HZ  = 20'h00002;
  localparam logic [19:0] FREQ_MAX_HZ  = 20'hf4240;
  // widths
  localparam int unsigned TW  = 24;  // time fields in clock cycles
  localparam int unsigned NW  = 16;  // frame and gate counts
  localparam int unsigned DVW = TW + NW;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_FREQ     = 8'h04;
  localparam logic [7:0] OFS_WSTART   = 8'h08;
  localparam logic [7:0] OFS_WEND     = 8'h0c;
  localparam logic [7:0] OFS_DSTART   = 8'h10;
  localparam logic [7:0] OFS_DEND     = 8'h14;
  localparam logic [7:0] OFS_FRAMES   = 8'h18;
  localparam logic [7:0] OFS_GATES    = 8'h1c;
  localparam logic [7:0] OFS_SYNCB_US = 8'h20;
  localparam logic [7:0] OFS_AUXW     = 8'h24;
  localparam logic [7:0] OFS_AUXD     = 8'h28;
  localparam logic [7:0] OFS_SYNCW    = 8'h2c;
  localparam logic [7:0] OFS_STATUS   = 8'h30;
  localparam logic [7:0] OFS_CURW     = 8'h34;
  localparam logic [7:0] OFS_CURD     = 8'h38;
  // control bit positions
  localparam int unsigned CB_EN     = 0;
  localparam int unsigned CB_EXT    = 1;
  localparam int unsigned CB_SYNC   = 2;
  localparam int unsigned CB_GBIAS  = 3;
  localparam int unsigned CB_SEQ    = 4;
  localparam int unsigned CTRL_W    = 5;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [19:0]       FREQ_RST = 20'h003e8;
  localparam logic [TW-1:0]     TIME_RST = 24'h000000;
  localparam logic [TW-1:0]     SYNCW_RST = 24'h00007d;
  localparam logic [NW-1:0]     CNT_RST  = 16'h0001;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // sequencer states
  typedef enum logic [1:0] {
    ST_CALC = 2'b00,
    ST_WAIT = 2'b01,
    ST_SET  = 2'b10,
    ST_TAIL = 2'b11
  } gitg_state_e;
endpackage : gitg_pkg

// file: verilog/gitg_div_if.sv
// request and answer bundle between sequencer and divider
`timescale 1ns/100ps
`default_nettype none
interface gitg_div_if;
  logic                     go;
  logic [gitg_pkg::DVW-1:0] dividend;
  logic [gitg_pkg::NW-1:0]  divisor;
  logic                     done;
  logic [gitg_pkg::DVW-1:0] quotient;
  modport req (output go, output dividend, output divisor, input done, input quotient);
  modport srv (input go, input dividend, input divisor, output done, output quotient);
endinterface : gitg_div_if
`default_nettype wire

// file: verilog/gitg_divider.sv
// iterative restoring divider, one quotient bit per clock
`timescale 1ns/100ps
`default_nettype none
module gitg_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request port
  gitg_div_if.srv  dv
);
  localparam int unsigned DVW = gitg_pkg::DVW;
  localparam int unsigned NW  = gitg_pkg::NW;

  logic [DVW-1:0] quo_ff;
  logic [NW-1:0]  rem_ff;
  logic [5:0]     cnt_ff;
  logic           busy_ff;
  logic           done_ff;
  logic [NW:0]    trial;

  assign trial       = {rem_ff, quo_ff[DVW-1]};
  assign dv.done     = done_ff;
  assign dv.quotient = quo_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quo_ff  <= '0;
      rem_ff  <= '0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (dv.go) begin
      quo_ff  <= dv.dividend;
      rem_ff  <= '0;
      cnt_ff  <= 6'(DVW);
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff) begin
      if (trial >= {1'b0, dv.divisor}) begin
        rem_ff <= NW'(trial - {1'b0, dv.divisor});
        quo_ff <= {quo_ff[DVW-2:0], 1'b1};
      end else begin
        rem_ff <= trial[NW-1:0];
        quo_ff <= {quo_ff[DVW-2:0], 1'b0};
      end
      cnt_ff <= cnt_ff - 6'h01;
      if (cnt_ff == 6'h01) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end else begin
      done_ff <= 1'b0;
    end
  end
endmodule : gitg_divider
`default_nettype wire

// file: verif/gitg_trig_src.sv
// trigger source model on the external trigger pin
`timescale 1ns/100ps
`default_nettype none
module gitg_trig_src (
  // clock
  input  wire logic clk,
  // trigger pin
  output logic      trig_in
);
  initial trig_in = 1'h0;
  // pulses 4 clocks high, gap is rise to rise
  task automatic fire(input int gap, input int cnt);
    repeat (cnt) begin
      trig_in <= 1'h1;
      repeat (4) @(posedge clk);
      trig_in <= 1'h0;
      repeat (gap - 4) @(posedge clk);
    end
  endtask : fire
endmodule : gitg_trig_src
`default_nettype wire

// file: verif/gitg_chk_sva.sv
// port assertions for the timing generator
`timescale 1ns/100ps
`default_nettype none
module gitg_chk (
  // watched ports
  input wire logic clk, rst_n, s_axi_bvalid, s_axi_bready, plate_gain_gate, gate_open_edge,
  input wire logic gate_close_edge, master_sync_out_a, exposure_active, cathode_bias_on, idle_flush
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_open; $rose(plate_gain_gate) |-> gate_open_edge; endproperty
  a_open: assert property (p_open) else $error("no open edge");
  property p_close; $fell(plate_gain_gate) |-> gate_close_edge; endproperty
  a_close: assert property (p_close) else $error("no close edge");
  property p_bias; plate_gain_gate |-> cathode_bias_on; endproperty
  a_bias: assert property (p_bias) else $error("bias off");
  property p_gexp; plate_gain_gate |-> exposure_active; endproperty
  a_gexp: assert property (p_gexp) else $error("gate unexposed");
  property p_sexp; master_sync_out_a |-> exposure_active; endproperty
  a_sexp: assert property (p_sexp) else $error("sync unexposed");
  property p_tail; $fell(exposure_active) |-> !$past(plate_gain_gate, 2) && !$past(master_sync_out_a, 2); endproperty
  a_tail: assert property (p_tail) else $error("short tail");
  property p_flush; idle_flush |-> !plate_gain_gate; endproperty
  a_flush: assert property (p_flush) else $error("flush in gate");
  property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bone: assert property (p_bone) else $error("response repeated");
endmodule : gitg_chk
bind gitg_timing_gen gitg_chk u_gitg_chk (.*);
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the timing generator
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [5:0] p = 6'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trig_in, plate_gain_gate;
  wire logic gate_open_edge, gate_close_edge, spare_pulse_one, master_sync_out_a, master_sync_out_b;
  wire logic exposure_active, cathode_bias_on, idle_flush;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [5:0] s = {~plate_gain_gate, ~spare_pulse_one, plate_gain_gate, spare_pulse_one,
                        master_sync_out_b, master_sync_out_a};
  int failures = 0, compares = 0, cyc = 0, na = 0, rt[6];
  gitg_timing_gen u_gitg_timing_gen (.*);
  gitg_trig_src u_gitg_trig_src (.*);
  always #4 clk = ~clk;
  // cycle of last rise of each watched output, and of last fall of spare_pulse_one and plate_gain_gate
  always @(posedge clk) begin
    cyc++;
    for (int k = 0; k < 6; k++) if (s[k] && !p[k]) rt[k] = cyc;
    na += int'(s[0] && !p[0]);
    p = s;
  end
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  task to;
    failures++;
    test_done;
  endtask : to
  // one axi4-lite write (w=1) or read
  task ax(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = gitg_pkg::RESP_OKAY);
    @(posedge clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    for (int n = 0; !(w ? s_axi_bvalid : s_axi_rvalid); n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n > 99) to;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    `CK("resp", e, w ? s_axi_bresp : s_axi_rresp)
    if (!w) `CK("rdata", d, s_axi_rdata)
  endtask : ax
  task wa;
    int e;
    e = rt[0];
    for (int n = 0; rt[0] == e; n++) begin
      @(negedge clk);
      if (n > 3000) to;
    end
  endtask : wa
  task t_reg;
    ax(1'h0, gitg_pkg::OFS_FREQ, 32'h3e8);
    ax(1'h0, 8'h3c, 32'h0, gitg_pkg::RESP_SLVERR);
    ax(1'h1, gitg_pkg::OFS_STATUS, 32'h1, gitg_pkg::RESP_SLVERR);
    $display("t_reg done");
  endtask : t_reg
  task t_int;
    int t;
    ax(1'h1, gitg_pkg::OFS_FREQ, 32'hf4240);
    ax(1'h1, gitg_pkg::OFS_DSTART, 32'ha);
    ax(1'h1, gitg_pkg::OFS_DEND, 32'h1e);
    ax(1'h1, gitg_pkg::OFS_WSTART, 32'h14);
    ax(1'h1, gitg_pkg::OFS_WEND, 32'h28);
    ax(1'h1, gitg_pkg::OFS_AUXD, 32'h5);
    ax(1'h1, gitg_pkg::OFS_AUXW, 32'h7);
    ax(1'h1, gitg_pkg::OFS_SYNCW, 32'h1e);
    ax(1'h1, gitg_pkg::OFS_FRAMES, 32'h3);
    ax(1'h1, gitg_pkg::OFS_CTRL, 32'h1d);
    for (int i = 0; i < 4; i++) begin
      wa;
      repeat (100) @(negedge clk);
      `CK("delay", 10 + 10 * (i % 3), rt[3] - rt[0])
      `CK("width", 20 + 10 * (i % 3), rt[5] - rt[3])
      `CK("auxd", 5, rt[2] - rt[0])
      `CK("auxw", 7, rt[4] - rt[2])
    end
    ax(1'h1, gitg_pkg::OFS_CTRL, 32'hd);
    wa;
    t = rt[0];
    wa;
    `CK("period", 125, rt[0] - t)
    $display("t_int done");
  endtask : t_int
  task t_ext;
    int n;
    ax(1'h1, gitg_pkg::OFS_SYNCB_US, 32'h1);
    ax(1'h1, gitg_pkg::OFS_CTRL, 32'h7);
    // let the last internal set and its tail run out
    repeat (40) @(posedge clk);
    n = na;
    u_gitg_trig_src.fire(400, 3);
    `CK("sets", 3, na - n)
    `CK("syncb", 125, rt[1] - rt[0])
    n = na;
    u_gitg_trig_src.fire(12, 3);
    repeat (60) @(posedge clk);
    `CK("drop", 1, na - n)
    $display("t_ext done");
  endtask : t_ext
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_reg;
    t_int;
    t_ext;
    test_done;
  end
endmodule : testbench
`default_nettype wire
